// ### src/pfm_top.sv
// Port function multiplexer for ports 6, A and B with AXI4-Lite access
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Port 6 carries DMA, chip-select and interrupt lines
// - Modes 1-3: upper port A is I/O plus interrupts
// - Mode 6 upper port A: dir 0 input, 1 address
// - Mode 6 port B, lower A: dir selects input or address
// - Ports A and B have switchable pad pull-ups
// - Each port has direction, output latch, pin readback
// - Separate per-pin pull-up control register for A, B
module pfm_top (
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // Mode strap pins
  input wire logic [2:0] mode_pins,
  // Pads of port 6, A and B
  input wire logic [7:0] p6_in,
  output logic [7:0] p6_out,
  output logic [7:0] p6_oe,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pullup,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pullup,
  // Bus controller and DMA side
  input wire logic [23:8] addr_in,
  input wire logic [7:4] chip_select_out,
  input wire logic [7:4] chip_select_en,
  input wire logic [1:0] dma_transfer_end_out,
  input wire logic [1:0] dma_transfer_end_en,
  output logic [1:0] dma_request_in,
  output logic [7:0] ext_interrupt_in,
  output logic [2:0] mode_sel,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------
  // Mode decode functions
  // ----------------------------------------------------------------

  // Lower port A kind per mode
  function automatic pfm_pkg::pfm_kind_t pa_lo_kind(input logic [2:0] m);
    case (m)
      pfm_pkg::MODE_4, pfm_pkg::MODE_5: pa_lo_kind = pfm_pkg::KIND_ADDR;
      pfm_pkg::MODE_6: pa_lo_kind = pfm_pkg::KIND_DIRADDR;
      default: pa_lo_kind = pfm_pkg::KIND_IO;
    endcase
  endfunction : pa_lo_kind

  // Upper port A kind per mode
  function automatic pfm_pkg::pfm_kind_t pa_hi_kind(input logic [2:0] m);
    case (m)
      pfm_pkg::MODE_4, pfm_pkg::MODE_5,
      pfm_pkg::MODE_6: pa_hi_kind = pfm_pkg::KIND_DIRADDR;
      default: pa_hi_kind = pfm_pkg::KIND_IO;
    endcase
  endfunction : pa_hi_kind

  // Port B kind per mode
  function automatic pfm_pkg::pfm_kind_t pb_kind(input logic [2:0] m);
    case (m)
      pfm_pkg::MODE_1, pfm_pkg::MODE_4,
      pfm_pkg::MODE_5: pb_kind = pfm_pkg::KIND_ADDR;
      pfm_pkg::MODE_2, pfm_pkg::MODE_6: pb_kind = pfm_pkg::KIND_DIRADDR;
      default: pb_kind = pfm_pkg::KIND_IO;
    endcase
  endfunction : pb_kind

  // Expanded modes with extra chip selects
  function automatic logic cs_mode(input logic [2:0] m);
    cs_mode = (m == pfm_pkg::MODE_4) || (m == pfm_pkg::MODE_5) ||
              (m == pfm_pkg::MODE_6);
  endfunction : cs_mode

  // Pad drive of a port from kinds, settings and address bits
  function automatic pfm_pkg::pfm_pad_t apply_kind(
    input pfm_pkg::pfm_kind_t lo,
    input pfm_pkg::pfm_kind_t hi,
    input pfm_pkg::pfm_cfg_t c,
    input logic [7:0] a
  );
    pfm_pkg::pfm_pad_t p;
    pfm_pkg::pfm_kind_t k;
    p = '0;
    for (int i = 0; i < 8; i++) begin
      k = (i < 4) ? lo : hi;
      case (k)
        pfm_pkg::KIND_ADDR: begin
          p.oe[i] = 1'b1;
          p.out[i] = a[i];
        end
        pfm_pkg::KIND_DIRADDR: begin
          p.oe[i] = c.dir[i];
          p.out[i] = a[i];
        end
        default: begin
          p.oe[i] = c.dir[i];
          p.out[i] = c.latch[i];
        end
      endcase
      p.pull[i] = c.pu[i] & ~p.oe[i];
    end
    apply_kind = p;
  endfunction : apply_kind

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pfm_pkg::pfm_state_t st_ff; // Registered state
  pfm_pkg::pfm_state_t nxt_st; // Next state

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Sync, mode capture, pin muxing and register bus
  always_comb begin
    logic [7:0] rd;
    logic rd_ok;
    logic [7:0] irq_gate;
    nxt_st = st_ff;
    rd = 8'h00;
    rd_ok = 1'b1;
    irq_gate = 8'hFF; // Every interrupt input open by default
    // Two-flop synchronisers for pads and strap pins
    nxt_st.s1_p6 = p6_in;
    nxt_st.s1_pa = pa_in;
    nxt_st.s1_pb = pb_in;
    nxt_st.s2_p6 = st_ff.s1_p6;
    nxt_st.s2_pa = st_ff.s1_pa;
    nxt_st.s2_pb = st_ff.s1_pb;
    nxt_st.s1_mode = mode_pins;
    nxt_st.s2_mode = st_ff.s1_mode;
    // Mode taken once after settling, then frozen
    if (!st_ff.mode_ok) begin
      if (st_ff.mode_cnt == pfm_pkg::MODE_SETTLE) begin
        nxt_st.mode = st_ff.s2_mode;
        nxt_st.mode_ok = 1'b1;
      end else begin
        nxt_st.mode_cnt = st_ff.mode_cnt + 2'h1;
      end
    end
    // Port A and B pads from mode and settings
    nxt_st.pada = apply_kind(pa_lo_kind(st_ff.mode),
      pa_hi_kind(st_ff.mode), st_ff.pa, addr_in[23:16]);
    nxt_st.padb = apply_kind(pb_kind(st_ff.mode),
      pb_kind(st_ff.mode), st_ff.pb, addr_in[15:8]);
    // Port 6: chip select over transfer end over plain I/O
    for (int i = 0; i < 8; i++) begin
      nxt_st.pad6.oe[i] = st_ff.p6.dir[i];
      nxt_st.pad6.out[i] = st_ff.p6.latch[i];
    end
    nxt_st.pad6.pull = 8'h00;
    if (dma_transfer_end_en[0]) begin
      nxt_st.pad6.oe[1] = 1'b1;
      nxt_st.pad6.out[1] = dma_transfer_end_out[0];
    end
    if (dma_transfer_end_en[1]) begin
      nxt_st.pad6.oe[3] = 1'b1;
      nxt_st.pad6.out[3] = dma_transfer_end_out[1];
    end
    if (cs_mode(st_ff.mode)) begin
      for (int j = 0; j < 4; j++) begin
        if (chip_select_en[j + 4]) begin
          nxt_st.pad6.oe[(j < 2) ? j : j + 4] = 1'b1;
          nxt_st.pad6.out[(j < 2) ? j : j + 4] = chip_select_out[j + 4];
        end
      end
    end
    // Interrupt and DMA request inputs; address pins feed none
    if (pa_hi_kind(st_ff.mode) == pfm_pkg::KIND_DIRADDR) begin
      irq_gate[7:4] = ~st_ff.pa.dir[7:4];
    end
    nxt_st.irq = {st_ff.s2_pa[7:4], st_ff.s2_p6[7:4]} & irq_gate;
    nxt_st.dreq = {st_ff.s2_p6[2], st_ff.s2_p6[0]};
    // Write address and data channels
    if (awvalid && st_ff.awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr = awaddr;
    end
    if (wvalid && st_ff.wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata = wdata[7:0];
      nxt_st.wlane0 = wstrb[0];
    end
    // Write performed once both halves are held
    if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = pfm_pkg::RESP_OKAY;
      case (st_ff.awaddr)
        pfm_pkg::OFS_P6_DIR: begin
          if (st_ff.wlane0) nxt_st.p6.dir = st_ff.wdata;
        end
        pfm_pkg::OFS_P6_OUT: begin
          if (st_ff.wlane0) nxt_st.p6.latch = st_ff.wdata;
        end
        pfm_pkg::OFS_PA_DIR: begin
          if (st_ff.wlane0) nxt_st.pa.dir = st_ff.wdata;
        end
        pfm_pkg::OFS_PA_OUT: begin
          if (st_ff.wlane0) nxt_st.pa.latch = st_ff.wdata;
        end
        pfm_pkg::OFS_PA_PU: begin
          if (st_ff.wlane0) nxt_st.pa.pu = st_ff.wdata;
        end
        pfm_pkg::OFS_PB_DIR: begin
          if (st_ff.wlane0) nxt_st.pb.dir = st_ff.wdata;
        end
        pfm_pkg::OFS_PB_OUT: begin
          if (st_ff.wlane0) nxt_st.pb.latch = st_ff.wdata;
        end
        pfm_pkg::OFS_PB_PU: begin
          if (st_ff.wlane0) nxt_st.pb.pu = st_ff.wdata;
        end
        default: nxt_st.bresp = pfm_pkg::RESP_SLVERR;
      endcase
    end else if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_have && !nxt_st.bvalid;
    // Read channel: pin state comes from the synchronised pads
    case (araddr)
      pfm_pkg::OFS_P6_DIR: rd = st_ff.p6.dir;
      pfm_pkg::OFS_P6_OUT: rd = st_ff.p6.latch;
      pfm_pkg::OFS_P6_PIN: rd = st_ff.s2_p6;
      pfm_pkg::OFS_PA_DIR: rd = st_ff.pa.dir;
      pfm_pkg::OFS_PA_OUT: rd = st_ff.pa.latch;
      pfm_pkg::OFS_PA_PIN: rd = st_ff.s2_pa;
      pfm_pkg::OFS_PA_PU: rd = st_ff.pa.pu;
      pfm_pkg::OFS_PB_DIR: rd = st_ff.pb.dir;
      pfm_pkg::OFS_PB_OUT: rd = st_ff.pb.latch;
      pfm_pkg::OFS_PB_PIN: rd = st_ff.s2_pb;
      pfm_pkg::OFS_PB_PU: rd = st_ff.pb.pu;
      pfm_pkg::OFS_MODE: rd = {5'h00, st_ff.mode};
      default: rd_ok = 1'b0;
    endcase
    if (arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd;
      nxt_st.rresp = rd_ok ? pfm_pkg::RESP_OKAY : pfm_pkg::RESP_SLVERR;
    end else if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    nxt_st.arready = !nxt_st.rvalid;
  end

  // State register, synchronous reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff <= pfm_pkg::ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign p6_out = st_ff.pad6.out;
  assign p6_oe = st_ff.pad6.oe;
  assign pa_out = st_ff.pada.out;
  assign pa_oe = st_ff.pada.oe;
  assign pa_pullup = st_ff.pada.pull;
  assign pb_out = st_ff.padb.out;
  assign pb_oe = st_ff.padb.oe;
  assign pb_pullup = st_ff.padb.pull;
  assign dma_request_in = st_ff.dreq;
  assign ext_interrupt_in = st_ff.irq;
  assign mode_sel = st_ff.mode;
  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rdata = {24'h000000, st_ff.rdata};
  assign rresp = st_ff.rresp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_mode_hold;
    st_ff.mode_ok |=> st_ff.mode_ok && $stable(st_ff.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("Mode changed after capture");

  property p_cs_drive;
    cs_mode(st_ff.mode) && chip_select_en[7] |=>
      p6_oe[7] && p6_out[7] == $past(chip_select_out[7]);
  endproperty
  a_cs_drive: assert property (p_cs_drive)
    else $error("Chip select 7 not on its pin");

  property p_dreq_pass;
    1'b1 |=> dma_request_in[1] == $past(st_ff.s2_p6[2]);
  endproperty
  a_dreq_pass: assert property (p_dreq_pass)
    else $error("DMA request 1 not passed");

  property p_low_irq;
    st_ff.mode_ok && st_ff.mode inside {[pfm_pkg::MODE_1:pfm_pkg::MODE_3]} |=>
      ext_interrupt_in[7:4] == $past(st_ff.s2_pa[7:4]);
  endproperty
  a_low_irq: assert property (p_low_irq)
    else $error("Upper port A interrupts lost");

  property p_m6_hi_addr;
    st_ff.mode == pfm_pkg::MODE_6 && st_ff.pa.dir[7] |=>
      pa_oe[7] && pa_out[7] == $past(addr_in[23]) && !ext_interrupt_in[7];
  endproperty
  a_m6_hi_addr: assert property (p_m6_hi_addr)
    else $error("Upper port A not address output");

  property p_m6_pb_in;
    st_ff.mode == pfm_pkg::MODE_6 && !st_ff.pb.dir[0] |=> !pb_oe[0];
  endproperty
  a_m6_pb_in: assert property (p_m6_pb_in)
    else $error("Port B pin driven while input");

  property p_m2_pb_addr;
    st_ff.mode == pfm_pkg::MODE_2 && st_ff.pb.dir[3] |=>
      pb_oe[3] && pb_out[3] == $past(addr_in[11]);
  endproperty
  a_m2_pb_addr: assert property (p_m2_pb_addr)
    else $error("Port B not address output");

  property p_pull_input;
    (pa_pullup & pa_oe) == 8'h00 && (pb_pullup & pb_oe) == 8'h00;
  endproperty
  a_pull_input: assert property (p_pull_input)
    else $error("Pull-up on a driven pin");

  property p_pin_read;
    arvalid && arready && araddr == pfm_pkg::OFS_PB_PIN |=>
      rvalid && rdata[7:0] == $past(st_ff.s2_pb);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("Pin state read wrong");

  property p_pu_write;
    st_ff.aw_have && st_ff.w_have && !st_ff.bvalid && st_ff.wlane0 &&
      st_ff.awaddr == pfm_pkg::OFS_PA_PU |=>
      st_ff.pa.pu == $past(st_ff.wdata) ##1
      pa_pullup == (st_ff.pa.pu & ~pa_oe);
  endproperty
  a_pu_write: assert property (p_pu_write)
    else $error("Pull-up write not applied");

  c_m6_addr: cover property (st_ff.mode == pfm_pkg::MODE_6 && pa_oe[7]);
  c_cs_on: cover property (p6_oe[0] && chip_select_en[4]);
  c_pull_on: cover property (pa_pullup != 8'h00);

endmodule : pfm_top

// ### src/pfm_pkg.sv
// Constants, register map and carrier types for the port function mux
package pfm_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (one 32-bit word each, data in bits 7:0)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_P6_DIR = 8'h00; // Port 6 direction
  localparam logic [7:0] OFS_P6_OUT = 8'h04; // Port 6 output_latch
  localparam logic [7:0] OFS_P6_PIN = 8'h08; // Port 6 pin state, read only
  localparam logic [7:0] OFS_PA_DIR = 8'h0C; // Port A direction
  localparam logic [7:0] OFS_PA_OUT = 8'h10; // Port A output_latch
  localparam logic [7:0] OFS_PA_PIN = 8'h14; // Port A pin state, read only
  localparam logic [7:0] OFS_PA_PU = 8'h18; // Port A pullup_control_bits
  localparam logic [7:0] OFS_PB_DIR = 8'h1C; // Port B direction
  localparam logic [7:0] OFS_PB_OUT = 8'h20; // Port B output_latch
  localparam logic [7:0] OFS_PB_PIN = 8'h24; // Port B pin state, read only
  localparam logic [7:0] OFS_PB_PU = 8'h28; // Port B pullup_control_bits
  localparam logic [7:0] OFS_MODE = 8'h2C; // Latched mode, read only

  // ----------------------------------------------------------------
  // Bus answers, reset values, timing
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0; // Access done
  localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped or read-only
  localparam logic [7:0] DIR_RST = 8'h00; // All pins input
  localparam logic [7:0] LATCH_RST = 8'h00; // Output latch cleared
  localparam logic [7:0] PU_RST = 8'h00; // Pull-ups off
  localparam logic [1:0] MODE_SETTLE = 2'h2; // Edges before mode capture

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] MODE_6 = 3'h6;

  // Pin group behaviour per mode
  typedef enum logic [1:0] {
    KIND_IO = 2'h0, // Plain I/O
    KIND_ADDR = 2'h1, // Fixed address output
    KIND_DIRADDR = 2'h2 // Input when dir 0, address when dir 1
  } pfm_kind_t;

  // Software settings of one port
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
    logic [7:0] pu;
  } pfm_cfg_t;

  // Pad drive of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } pfm_pad_t;

  // Whole block state
  typedef struct packed {
    pfm_cfg_t p6;
    pfm_cfg_t pa;
    pfm_cfg_t pb;
    logic [7:0] s1_p6;
    logic [7:0] s1_pa;
    logic [7:0] s1_pb;
    logic [7:0] s2_p6;
    logic [7:0] s2_pa;
    logic [7:0] s2_pb;
    logic [2:0] s1_mode;
    logic [2:0] s2_mode;
    logic [1:0] mode_cnt;
    logic mode_ok;
    logic [2:0] mode;
    pfm_pad_t pad6;
    pfm_pad_t pada;
    pfm_pad_t padb;
    logic [7:0] irq;
    logic [1:0] dreq;
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wlane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } pfm_state_t;

  localparam pfm_state_t ST_RST = '0; // Reset image of the state

endpackage : pfm_pkg

// ### verif/pfm_pad_model.sv
// Pad wire model: design drive, outside drive, pull-up or floating pin
`timescale 1ns/1ps
module pfm_pad_model (
  // Clock for the floating pattern
  input wire logic clock,
  // Design side of the pad
  input wire logic [7:0] oe,
  input wire logic [7:0] out,
  input wire logic [7:0] pull,
  // Outside driver on the board
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved pin level
  output logic [7:0] pin
);
  logic [7:0] float_ff = 8'h55; // Undriven pins wander
  // Floating pattern flips every cycle
  always_ff @(posedge clock) begin
    float_ff <= ~float_ff;
  end
  // Design first, then board, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe[i]) begin
        pin[i] = out[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_val[i];
      end else if (pull[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = float_ff[i];
      end
    end
  end
endmodule : pfm_pad_model

// ### verif/tb.sv
// Self-checking bench for the port function multiplexer
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock = 1'b0, sys_rst = 1'b1; // Clock and reset
  logic [2:0] mode_pins = 3'h0; // Strap pins
  logic [7:0] p6_in, p6_out, p6_oe, pa_in, pa_out, pa_oe, pa_pullup;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pullup;
  logic [7:0] e6 = 8'h00, v6 = 8'h00, ea = 8'h00, va = 8'h00; // Board
  logic [15:0] addr_in = 16'h0000; // Bus controller address
  logic [3:0] cs_out = 4'h0, cs_en = 4'h0; // Chip selects
  logic [1:0] te_out = 2'h0, te_en = 2'h0; // Transfer end
  logic [1:0] dma_request_in, bresp, rresp;
  logic [7:0] ext_interrupt_in, awaddr = 8'h00, araddr = 8'h00;
  logic [2:0] mode_sel;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  int fails = 0, checks = 0, cyc = 0; // Counters
  // Clock at 200 MHz
  initial begin
    forever #2.5 clock = ~clock;
  end
  pfm_top i_dut (.clock(clock), .sys_rst(sys_rst), .mode_pins(mode_pins),
    .p6_in(p6_in), .p6_out(p6_out), .p6_oe(p6_oe), .pa_in(pa_in),
    .pa_out(pa_out), .pa_oe(pa_oe), .pa_pullup(pa_pullup), .pb_in(pb_in),
    .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup),
    .addr_in(addr_in), .chip_select_out(cs_out), .chip_select_en(cs_en),
    .dma_transfer_end_out(te_out), .dma_transfer_end_en(te_en),
    .dma_request_in(dma_request_in), .ext_interrupt_in(ext_interrupt_in),
    .mode_sel(mode_sel), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // Pads: port 6 has no pull-ups, port B is never board-driven
  pfm_pad_model i_m6 (.clock(clock), .oe(p6_oe), .out(p6_out),
    .pull(8'h00), .ext_en(e6), .ext_val(v6), .pin(p6_in));
  pfm_pad_model i_ma (.clock(clock), .oe(pa_oe), .out(pa_out),
    .pull(pa_pullup), .ext_en(ea), .ext_val(va), .pin(pa_in));
  pfm_pad_model i_mb (.clock(clock), .oe(pb_oe), .out(pb_out),
    .pull(pb_pullup), .ext_en(8'h00), .ext_val(8'h00), .pin(pb_in));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // Cut a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end
  task rst(input logic [2:0] m);
    mode_pins <= m;
    sys_rst <= 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clock);
  endtask : rst
  task settle;
    repeat (6) @(posedge clock);
  endtask : settle
  // Write one register; address and data released when each is taken
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ah, wh;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ah && wh)) begin
      @(posedge clock);
      if (!ah && awready === 1'b1) begin
        awvalid <= 1'b0;
        ah = 1'b1;
      end
      if (!wh && wready === 1'b1) begin
        wvalid <= 1'b0;
        wh = 1'b1;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask : wr
  // Read one register and compare data and response
  task rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", rdata, {24'h000000, ed});
    chk("rresp", rresp, er);
  endtask : rd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    chk("mode_sel", mode_sel, pfm_pkg::MODE_6);
    rd(pfm_pkg::OFS_P6_DIR, pfm_pkg::DIR_RST, pfm_pkg::RESP_OKAY);
    rd(pfm_pkg::OFS_PA_DIR, pfm_pkg::DIR_RST, pfm_pkg::RESP_OKAY);
    rd(pfm_pkg::OFS_PB_OUT, pfm_pkg::LATCH_RST, pfm_pkg::RESP_OKAY);
    rd(pfm_pkg::OFS_PB_PU, pfm_pkg::PU_RST, pfm_pkg::RESP_OKAY);
    rd(8'h30, 8'h00, pfm_pkg::RESP_SLVERR);
    wr(pfm_pkg::OFS_PA_PIN, 8'hFF, pfm_pkg::RESP_SLVERR);
    wr(pfm_pkg::OFS_PB_OUT, 8'hA5, pfm_pkg::RESP_OKAY);
    rd(pfm_pkg::OFS_PB_OUT, 8'hA5, pfm_pkg::RESP_OKAY);
    $display("t_regs done");
  endtask : t_regs
  task t_p6;
    e6 <= 8'hFF;
    v6 <= 8'hA4;
    settle;
    chk("dreq", dma_request_in, 2'h2);
    chk("irq_lo", ext_interrupt_in[3:0], 4'hA);
    rd(pfm_pkg::OFS_P6_PIN, 8'hA4, pfm_pkg::RESP_OKAY);
    e6 <= 8'h54;
    cs_en <= 4'hB;
    cs_out <= 4'hA;
    te_en <= 2'h3;
    te_out <= 2'h2;
    wr(pfm_pkg::OFS_P6_DIR, 8'h20, pfm_pkg::RESP_OKAY);
    wr(pfm_pkg::OFS_P6_OUT, 8'h20, pfm_pkg::RESP_OKAY);
    settle;
    chk("p6_oe", p6_oe, 8'hAB);
    chk("p6_out", p6_out, 8'hAA);
    $display("t_p6 done");
  endtask : t_p6
  task t_pa6;
    ea <= 8'hF0;
    va <= 8'hF0;
    settle;
    chk("irq_hi", ext_interrupt_in[7:4], 4'hF);
    addr_in <= 16'hC35A;
    ea <= 8'h70;
    wr(pfm_pkg::OFS_PA_DIR, 8'h81, pfm_pkg::RESP_OKAY);
    settle;
    chk("pa_oe", pa_oe, 8'h81);
    chk("pa_out", pa_out & 8'h81, 8'h81);
    chk("irq_hi", ext_interrupt_in[7:4], 4'h7);
    $display("t_pa6 done");
  endtask : t_pa6
  task t_pb6;
    wr(pfm_pkg::OFS_PB_DIR, 8'h0F, pfm_pkg::RESP_OKAY);
    wr(pfm_pkg::OFS_PB_PU, 8'hF0, pfm_pkg::RESP_OKAY);
    wr(pfm_pkg::OFS_PA_PU, 8'hFF, pfm_pkg::RESP_OKAY);
    settle;
    chk("pb_oe", pb_oe, 8'h0F);
    chk("pb_out", pb_out[3:0], 4'hA);
    chk("pb_pullup", pb_pullup, 8'hF0);
    chk("pa_pullup", pa_pullup, 8'h7E);
    rd(pfm_pkg::OFS_PA_PU, 8'hFF, pfm_pkg::RESP_OKAY);
    rd(pfm_pkg::OFS_PB_PIN, 8'hFA, pfm_pkg::RESP_OKAY);
    $display("t_pb6 done");
  endtask : t_pb6
  task t_mode2;
    rst(pfm_pkg::MODE_2);
    chk("mode_sel", mode_sel, pfm_pkg::MODE_2);
    addr_in <= 16'h435A;
    va <= 8'h50;
    cs_en <= 4'h1;
    cs_out <= 4'h1;
    wr(pfm_pkg::OFS_PA_DIR, 8'h80, pfm_pkg::RESP_OKAY);
    wr(pfm_pkg::OFS_PA_OUT, 8'h80, pfm_pkg::RESP_OKAY);
    wr(pfm_pkg::OFS_PB_DIR, 8'h09, pfm_pkg::RESP_OKAY);
    wr(pfm_pkg::OFS_PB_OUT, 8'h01, pfm_pkg::RESP_OKAY);
    mode_pins <= pfm_pkg::MODE_5;
    settle;
    chk("pa_oe", pa_oe, 8'h80);
    chk("pa_out", pa_out[7], 1'b1);
    chk("irq_hi", ext_interrupt_in[7:4], 4'hD);
    chk("pb_oe", pb_oe, 8'h09);
    chk("pb_out", pb_out & 8'h09, 8'h08);
    chk("p6_oe", p6_oe, 8'h00);
    chk("mode_sel", mode_sel, pfm_pkg::MODE_2);
    rd(pfm_pkg::OFS_MODE, {5'h00, pfm_pkg::MODE_2}, pfm_pkg::RESP_OKAY);
    $display("t_mode2 done");
  endtask : t_mode2
  // Mode 4 fixed address and chip select 6, then mode 1 interrupts
  task t_mode41;
    rst(pfm_pkg::MODE_4);
    cs_en <= 4'h4;
    cs_out <= 4'h4;
    settle;
    chk("pa_oe", pa_oe, 8'h0F);
    chk("pa_out", pa_out & 8'h0F, 8'h03);
    chk("pb_out", pb_out, 8'h5A);
    chk("p6_oe", p6_oe, 8'h40);
    chk("p6_out", p6_out, 8'h40);
    rst(pfm_pkg::MODE_1);
    ea <= 8'hF0;
    va <= 8'hA0;
    settle;
    chk("irq_hi", ext_interrupt_in[7:4], 4'hA);
    chk("pb_oe", pb_oe, 8'hFF);
    chk("p6_oe", p6_oe, 8'h00);
    $display("t_mode41 done");
  endtask : t_mode41
  // Main sequence
  initial begin
    rst(pfm_pkg::MODE_6);
    t_regs;
    t_p6;
    cs_en <= 4'h0;
    te_en <= 2'h0;
    t_pa6;
    t_pb6;
    t_mode2;
    t_mode41;
    tally_and_finish;
  end
endmodule : tb
